// file: logic/usdbm_pkg.sv
// Constants and types of the serial transceiver data, baud and biphase register block.
// Contract
// - Reading receive holding clears character-available flag.
// - Receive holding shows 9-bit char, sync in bit15.
// - Per-char sync: bit one sends command sync.
// - Transmit char field holds pending character.
// - Async: divider zero stops; else 16/8 times divider.
// - Sync/SPI: divider zero stops; else divider alone.
// - Card ratio zero stops; else divides by ratio.
// - Fraction field adds eighths to divider.
// - Idle limit zero disables; else limit bit periods.
// - Idle counter width is an instance parameter.
// - Guard zero disables; else guard bit periods idle.
// - Card error counter, 8 bits, cleared on read.
// - 8-bit writable infrared filter setting.
// - Drift tracking only when set and 16x.
// - Polarity bit selects biphase transition direction.
// - Preamble kinds: ones, zeros, zero-one, one-zero.
// - Receive preamble length zero disables detection.
// - Transmit preamble length zero disables generation.
// - Character-available set until holding register read.
package usdbm_pkg;
	localparam logic [7:0] OFF_RX_HOLD = 8'h18;
	localparam logic [7:0] OFF_TX_HOLD = 8'h1C;
	localparam logic [7:0] OFF_BAUD_DIV = 8'h20;
	localparam logic [7:0] OFF_RX_IDLE = 8'h24;
	localparam logic [7:0] OFF_TX_GUARD = 8'h28;
	localparam logic [7:0] OFF_CARD_RATIO = 8'h40;
	localparam logic [7:0] OFF_ISO_ERR = 8'h44;
	localparam logic [7:0] OFF_IR_FILTER = 8'h4C;
	localparam logic [7:0] OFF_BIPHASE = 8'h50;
	localparam int SYNC_BIT = 15;
	localparam int FRAC_LSB = 16;
	localparam int DRIFT_BIT = 30;
	localparam int RX_POL_BIT = 28;
	localparam int RX_PREAMBLE_KIND_LSB = 24;
	localparam int RX_PREAMBLE_LEN_LSB = 16;
	localparam int TX_POL_BIT = 12;
	localparam int TX_PREAMBLE_KIND_LSB = 8;
	localparam int TX_PREAMBLE_LEN_LSB = 0;
	localparam logic [31:0] RST_CARD_RATIO = 32'h0000_0174;
	localparam logic [31:0] RST_BIPHASE = 32'h3001_1004;
	localparam logic [31:0] BIPHASE_WMASK = 32'h530F_130F;
	localparam logic [31:0] BIPHASE_FIXED = 32'h2000_0000;
	localparam logic [3:0] OS16_LAST = 4'hF;
	localparam logic [3:0] OS8_LAST = 4'h7;
	localparam logic [1:0] PP_ALL_ONE = 2'h0;
	localparam logic [1:0] PP_ALL_ZERO = 2'h1;
	localparam logic [1:0] PP_ZERO_ONE = 2'h2;
	localparam logic [1:0] PP_ONE_ZERO = 2'h3;

	typedef struct packed {
		logic sync_mode;
		logic spi_mode;
		logic iso_mode;
		logic over8;
		logic per_char_sync_sel;
	} usdbm_mode_t;

	typedef struct packed {
		logic [8:0] chr;
		logic command;
		logic hold_free;
	} usdbm_tx_t;

	typedef struct packed {
		logic drift_track;
		logic rx_pol;
		logic tx_pol;
		logic [7:0] ir_filter;
	} usdbm_line_cfg_t;
endpackage

// file: logic/usdbm_regs.sv
// Register file, baud generator, idle time-out, guard, error count and preamble logic.
`timescale 1ns/1ns
module usdbm_regs #(
	parameter int TO_W = 16
) (
	input wire logic clk, // 20 MHz clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	input wire usdbm_pkg::usdbm_mode_t mode, // operating mode
	input wire logic rx_valid, // received character pulse
	input wire logic [8:0] rx_char, // received character
	input wire logic rx_sync_kind, // 1 command sync, 0 data sync
	input wire logic tx_take, // shifter takes pending char
	input wire logic tx_done, // character finished on line
	input wire logic iso_err, // card transfer error pulse
	input wire logic rx_halves_valid, // decoded half-bit pair valid
	input wire logic [1:0] rx_halves, // first, second half levels
	input wire logic tx_pre_start, // start a transmit preamble
	output usdbm_pkg::usdbm_tx_t tx_out, // pending character
	output usdbm_pkg::usdbm_line_cfg_t line_cfg, // line settings
	output logic rx_char_avail, // character available
	output logic baud_tick, // baud generator output pulse
	output logic bit_tick, // one pulse per bit period
	output logic rx_idle_expired, // idle time-out flag
	output logic tx_guard_busy, // guard delay in progress
	output logic tx_pre_busy, // preamble being sent
	output logic [1:0] tx_pre_halves, // preamble half-bit levels
	output logic rx_pre_found // preamble detected pulse
);

	// ****************************************
	// Functions
	// ****************************************

	// Bit of a preamble pattern at alternating index.
	function automatic logic pre_bit(input logic [1:0] kind, input logic idx);
		logic b;
		b = 1'b0;
		unique case (kind)
			usdbm_pkg::PP_ALL_ONE: b = 1'b1;
			usdbm_pkg::PP_ALL_ZERO: b = 1'b0;
			usdbm_pkg::PP_ZERO_ONE: b = idx;
			usdbm_pkg::PP_ONE_ZERO: b = ~idx;
		endcase
		return b;
	endfunction

	// Half-bit levels of a biphase coded bit.
	function automatic logic [1:0] encode(input logic b, input logic pol);
		return (b ^ pol) ? 2'h2 : 2'h1;
	endfunction

	// ****************************************
	// Registers
	// ****************************************

	logic [8:0] rx_char_r;
	logic rx_sync_r;
	logic rx_avail_r;
	logic [8:0] tx_char_r;
	logic tx_sync_r;
	logic tx_free_r;
	logic [31:0] baud_r;
	logic [15:0] idle_r;
	logic [7:0] guard_r;
	logic [10:0] ratio_r;
	logic [7:0] err_r;
	logic [7:0] ir_r;
	logic [31:0] bip_r;
	logic [31:0] rdata_r;

	wire wr_tx = wr && addr == usdbm_pkg::OFF_TX_HOLD;
	wire wr_baud = wr && addr == usdbm_pkg::OFF_BAUD_DIV;
	wire wr_idle = wr && addr == usdbm_pkg::OFF_RX_IDLE;
	wire wr_guard = wr && addr == usdbm_pkg::OFF_TX_GUARD;
	wire wr_ratio = wr && addr == usdbm_pkg::OFF_CARD_RATIO;
	wire wr_ir = wr && addr == usdbm_pkg::OFF_IR_FILTER;
	wire wr_bip = wr && addr == usdbm_pkg::OFF_BIPHASE;
	wire rd_rx = rd && addr == usdbm_pkg::OFF_RX_HOLD;
	wire rd_err = rd && addr == usdbm_pkg::OFF_ISO_ERR;

	wire [15:0] cd = baud_r[15:0];
	wire [2:0] fp = baud_r[usdbm_pkg::FRAC_LSB +: 3];
	wire [1:0] rx_preamble_kind = bip_r[usdbm_pkg::RX_PREAMBLE_KIND_LSB +: 2];
	wire [3:0] rx_preamble_len = bip_r[usdbm_pkg::RX_PREAMBLE_LEN_LSB +: 4];
	wire [1:0] tx_preamble_kind = bip_r[usdbm_pkg::TX_PREAMBLE_KIND_LSB +: 2];
	wire [3:0] tx_preamble_len = bip_r[usdbm_pkg::TX_PREAMBLE_LEN_LSB +: 4];
	wire rx_pol = bip_r[usdbm_pkg::RX_POL_BIT];
	wire tx_pol = bip_r[usdbm_pkg::TX_POL_BIT];

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr)
			usdbm_pkg::OFF_RX_HOLD: begin
				rd_mux[8:0] = rx_char_r;
				rd_mux[usdbm_pkg::SYNC_BIT] = rx_sync_r;
			end
			usdbm_pkg::OFF_BAUD_DIV: rd_mux = baud_r;
			usdbm_pkg::OFF_RX_IDLE: rd_mux[15:0] = idle_r;
			usdbm_pkg::OFF_TX_GUARD: rd_mux[7:0] = guard_r;
			usdbm_pkg::OFF_CARD_RATIO: rd_mux[10:0] = ratio_r;
			usdbm_pkg::OFF_ISO_ERR: rd_mux[7:0] = err_r;
			usdbm_pkg::OFF_IR_FILTER: rd_mux[7:0] = ir_r;
			usdbm_pkg::OFF_BIPHASE: rd_mux = bip_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			baud_r <= 32'h0000_0000;
			idle_r <= 16'h0000;
			guard_r <= 8'h00;
			ratio_r <= usdbm_pkg::RST_CARD_RATIO[10:0];
			ir_r <= 8'h00;
			bip_r <= usdbm_pkg::RST_BIPHASE;
		end else begin
			if (wr_baud) begin
				baud_r <= {13'h0000, wdata[18:0]};
			end
			if (wr_idle) begin
				idle_r <= wdata[15:0];
			end
			if (wr_guard) begin
				guard_r <= wdata[7:0];
			end
			if (wr_ratio) begin
				ratio_r <= wdata[10:0];
			end
			if (wr_ir) begin
				ir_r <= wdata[7:0];
			end
			if (wr_bip) begin
				bip_r <= (wdata & usdbm_pkg::BIPHASE_WMASK) | usdbm_pkg::BIPHASE_FIXED;
			end
		end
	end

	// ****************************************
	// Holding registers
	// ****************************************

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_char_r <= 9'h000;
			rx_sync_r <= 1'b0;
			rx_avail_r <= 1'b0;
		end else begin
			if (rx_valid) begin
				rx_char_r <= rx_char;
				rx_sync_r <= rx_sync_kind;
				rx_avail_r <= 1'b1;
			end else if (rd_rx) begin
				rx_avail_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_char_r <= 9'h000;
			tx_sync_r <= 1'b0;
			tx_free_r <= 1'b1;
		end else begin
			if (wr_tx) begin
				tx_char_r <= wdata[8:0];
				tx_sync_r <= wdata[usdbm_pkg::SYNC_BIT];
				tx_free_r <= 1'b0;
			end else if (tx_take) begin
				tx_free_r <= 1'b1;
			end
		end
	end

	assign tx_out.chr = tx_char_r;
	assign tx_out.command = mode.per_char_sync_sel & tx_sync_r;
	assign tx_out.hold_free = tx_free_r;
	assign rx_char_avail = rx_avail_r;
	assign rdata = rdata_r;

	// ****************************************
	// Baud generator
	// ****************************************

	logic [15:0] div_cnt_r;
	logic [2:0] frac_acc_r;
	logic extra_r;
	logic [3:0] os_cnt_r;
	logic [10:0] iso_cnt_r;

	wire iso_stop = mode.iso_mode && ratio_r == 11'h000;
	wire baud_en = cd != 16'h0000 && !iso_stop;
	wire [16:0] limit = {1'b0, cd} - 17'h00001 + {16'h0000, extra_r};
	wire base_tick = baud_en && {1'b0, div_cnt_r} >= limit;
	wire [3:0] frac_sum = {1'b0, frac_acc_r} + {1'b0, fp};
	wire plain_mode = mode.sync_mode || mode.spi_mode;
	wire [3:0] os_last = mode.over8 ? usdbm_pkg::OS8_LAST : usdbm_pkg::OS16_LAST;
	wire os_wrap = os_cnt_r == os_last;
	wire iso_wrap = iso_cnt_r == ratio_r - 11'h001;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt_r <= 16'h0000;
			frac_acc_r <= 3'h0;
			extra_r <= 1'b0;
		end else if (!baud_en) begin
			div_cnt_r <= 16'h0000;
			frac_acc_r <= 3'h0;
			extra_r <= 1'b0;
		end else if (base_tick) begin
			div_cnt_r <= 16'h0000;
			frac_acc_r <= frac_sum[2:0];
			extra_r <= frac_sum[3];
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			os_cnt_r <= 4'h0;
			iso_cnt_r <= 11'h000;
		end else if (!baud_en) begin
			os_cnt_r <= 4'h0;
			iso_cnt_r <= 11'h000;
		end else if (base_tick) begin
			os_cnt_r <= os_wrap ? 4'h0 : os_cnt_r + 4'h1;
			iso_cnt_r <= iso_wrap ? 11'h000 : iso_cnt_r + 11'h001;
		end
	end

	assign baud_tick = base_tick;

	always_comb begin
		if (mode.iso_mode) begin
			bit_tick = base_tick && iso_wrap;
		end else if (plain_mode) begin
			bit_tick = base_tick;
		end else begin
			bit_tick = base_tick && os_wrap;
		end
	end

	// ****************************************
	// Idle time-out and guard
	// ****************************************

	logic [TO_W-1:0] idle_cnt_r;
	logic idle_armed_r;
	logic idle_exp_r;
	logic [7:0] guard_cnt_r;

	wire [TO_W-1:0] idle_lim = idle_r[TO_W-1:0];
	wire idle_on = idle_lim != '0;
	wire idle_hit = idle_armed_r && bit_tick && idle_cnt_r == idle_lim - TO_W'(1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_cnt_r <= '0;
			idle_armed_r <= 1'b0;
			idle_exp_r <= 1'b0;
		end else if (rx_valid || !idle_on) begin
			idle_cnt_r <= '0;
			idle_armed_r <= rx_valid && idle_on;
			idle_exp_r <= 1'b0;
		end else if (idle_hit) begin
			idle_armed_r <= 1'b0;
			idle_exp_r <= 1'b1;
		end else if (idle_armed_r && bit_tick) begin
			idle_cnt_r <= idle_cnt_r + TO_W'(1);
		end
	end

	assign rx_idle_expired = idle_exp_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			guard_cnt_r <= 8'h00;
		end else if (tx_done) begin
			guard_cnt_r <= guard_r;
		end else if (bit_tick && guard_cnt_r != 8'h00) begin
			guard_cnt_r <= guard_cnt_r - 8'h01;
		end
	end

	assign tx_guard_busy = guard_cnt_r != 8'h00;

	// ****************************************
	// Card error counter
	// ****************************************

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_r <= 8'h00;
		end else if (rd_err) begin
			err_r <= {7'h00, iso_err};
		end else if (iso_err && err_r != 8'hFF) begin
			err_r <= err_r + 8'h01;
		end
	end

	// ****************************************
	// Preamble generation and detection
	// ****************************************

	logic [3:0] txp_cnt_r;
	logic txp_idx_r;
	logic [3:0] rxp_cnt_r;
	logic rxp_idx_r;
	logic rxp_found_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txp_cnt_r <= 4'h0;
			txp_idx_r <= 1'b0;
		end else if (tx_pre_start) begin
			txp_cnt_r <= tx_preamble_len;
			txp_idx_r <= 1'b0;
		end else if (bit_tick && txp_cnt_r != 4'h0) begin
			txp_cnt_r <= txp_cnt_r - 4'h1;
			txp_idx_r <= ~txp_idx_r;
		end
	end

	assign tx_pre_busy = txp_cnt_r != 4'h0;
	assign tx_pre_halves = tx_pre_busy ? encode(pre_bit(tx_preamble_kind, txp_idx_r), tx_pol) : 2'h0;

	wire rx_bit = rx_halves[1] ^ rx_pol;
	wire rx_match = rx_bit == pre_bit(rx_preamble_kind, rxp_idx_r);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxp_cnt_r <= 4'h0;
			rxp_idx_r <= 1'b0;
			rxp_found_r <= 1'b0;
		end else if (rx_preamble_len == 4'h0 || !rx_halves_valid) begin
			rxp_found_r <= 1'b0;
		end else if (rx_match && rxp_cnt_r + 4'h1 == rx_preamble_len) begin
			rxp_cnt_r <= 4'h0;
			rxp_idx_r <= 1'b0;
			rxp_found_r <= 1'b1;
		end else if (rx_match) begin
			rxp_cnt_r <= rxp_cnt_r + 4'h1;
			rxp_idx_r <= ~rxp_idx_r;
			rxp_found_r <= 1'b0;
		end else begin
			rxp_cnt_r <= 4'h0;
			rxp_idx_r <= 1'b0;
			rxp_found_r <= 1'b0;
		end
	end

	assign rx_pre_found = rxp_found_r;

	assign line_cfg.drift_track = bip_r[usdbm_pkg::DRIFT_BIT] & ~mode.over8;
	assign line_cfg.rx_pol = rx_pol;
	assign line_cfg.tx_pol = tx_pol;
	assign line_cfg.ir_filter = ir_r;

endmodule

// file: tb/usdbm_regs_checker.sv
// Assertion checker bound to the serial transceiver register block.
`timescale 1ns/1ns
module usdbm_regs_checker #(
	parameter int TO_W = 16
) (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic [7:0] addr, // address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [31:0] rdata, // read data
	input wire usdbm_pkg::usdbm_mode_t mode, // mode
	input wire logic rx_valid, // char pulse
	input wire logic iso_err, // error pulse
	input wire usdbm_pkg::usdbm_tx_t tx_out, // pending char
	input wire usdbm_pkg::usdbm_line_cfg_t line_cfg, // settings
	input wire logic rx_char_avail // char available
);
	// ****
	// Properties
	// ****
	logic [31:0] wdata_q;
	logic drift_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdata_q <= '0;
			drift_q <= 1'b0;
		end else begin
			wdata_q <= wdata;
			if (wr && addr == usdbm_pkg::OFF_BIPHASE) begin
				drift_q <= wdata[usdbm_pkg::DRIFT_BIT];
			end
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence err_rd;
		rd && addr == usdbm_pkg::OFF_ISO_ERR && !iso_err;
	endsequence
	sequence hold_rd;
		rd && addr == usdbm_pkg::OFF_RX_HOLD && !rx_valid;
	endsequence
	rd_clear_a: assert property (hold_rd |=> !rx_char_avail)
		else $error("available flag kept after read");
	rx_set_a: assert property (rx_valid |=> rx_char_avail)
		else $error("available flag not set");
	tx_load_a: assert property (wr && addr == usdbm_pkg::OFF_TX_HOLD |=>
		!tx_out.hold_free && tx_out.chr == wdata_q[8:0]) else $error("pending char wrong");
	tx_sync_a: assert property (wr && addr == usdbm_pkg::OFF_TX_HOLD && wdata[15] ##1
		mode.per_char_sync_sel |-> tx_out.command) else $error("command sync missing");
	ir_filt_a: assert property (wr && addr == usdbm_pkg::OFF_IR_FILTER |=>
		line_cfg.ir_filter == wdata_q[7:0]) else $error("filter setting wrong");
	err_clear_a: assert property (err_rd ##1 !iso_err ##1 err_rd |=> rdata == 32'h0000_0000)
		else $error("error count not cleared");
	pol_write_a: assert property (wr && addr == usdbm_pkg::OFF_BIPHASE |=>
		line_cfg.rx_pol == wdata_q[28] && line_cfg.tx_pol == wdata_q[12]) else $error("polarity wrong");
	drift_gate_a: assert property (line_cfg.drift_track == (drift_q && !mode.over8))
		else $error("drift tracking setting wrong");
endmodule
bind usdbm_regs usdbm_regs_checker #(.TO_W(TO_W)) u_usdbm_regs_checker (.clk, .rst, .addr, .wdata, .wr, .rd,
	.rdata, .mode, .rx_valid, .iso_err, .tx_out, .line_cfg, .rx_char_avail);

// file: tb/usdbm_line_partner.sv
// Behavioural model of the serial line side that feeds the register block.
`timescale 1ns/1ns
module usdbm_line_partner (
	input wire logic clk, // clock
	output logic rx_valid, // char pulse
	output logic [8:0] rx_char, // char
	output logic rx_sync_kind, // sync kind
	output logic tx_take, // take pulse
	output logic tx_done, // done pulse
	output logic iso_err, // error pulse
	output logic rx_halves_valid, // halves pulse
	output logic [1:0] rx_halves, // halves
	output logic tx_pre_start // preamble start
);
	logic [5:0] ev = '0;
	assign {tx_pre_start, rx_halves_valid, iso_err, tx_done, tx_take, rx_valid} = ev;
	initial begin
		rx_char = '0;
		rx_sync_kind = 1'b0;
		rx_halves = '0;
	end
	// Data lines show the inverse once the pulse is over, so stale values never pass.
	task automatic pulse(input int k, input logic [8:0] c, input logic s);
		@(posedge clk);
		ev <= 6'h01 << k;
		rx_char <= c;
		rx_sync_kind <= s;
		rx_halves <= c[1:0];
		@(posedge clk);
		ev <= '0;
		rx_char <= ~c;
		rx_sync_kind <= ~s;
		rx_halves <= ~c[1:0];
	endtask
endmodule

// file: tb/usdbm_regs_tb.sv
// Self-checking bench for the serial transceiver register block.
`timescale 1ns/1ns
module usdbm_regs_tb;
	logic clk, rst, wr, rd, rx_valid, rx_sync_kind, tx_take, tx_done, iso_err, rx_halves_valid, tx_pre_start;
	logic rx_char_avail, baud_tick, bit_tick, rx_idle_expired, tx_guard_busy, tx_pre_busy, rx_pre_found;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [8:0] rx_char;
	logic [1:0] rx_halves, tx_pre_halves;
	usdbm_pkg::usdbm_mode_t mode;
	usdbm_pkg::usdbm_tx_t tx_out;
	usdbm_pkg::usdbm_line_cfg_t line_cfg;
	int miscompares = 0;
	int comparisons = 0;
	int n;
	int m;
	logic [7:0] ra [10] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h40, 8'h44, 8'h4C, 8'h50, 8'h30};
	logic [31:0] rr [10] = '{0, 0, 0, 0, 0, 32'h174, 0, 0, 32'h3001_1004, 0};
	logic [31:0] rm [10] = '{0, 0, 32'h7FFFF, 32'hFFFF, 32'hFF, 32'h7FF, 0, 32'hFF, 32'h730F_130F, 0};
	logic [4:0] bm [6] = '{5'h00, 5'h02, 5'h10, 5'h08, 5'h04, 5'h10};
	logic [31:0] bd [6] = '{2, 2, 3, 3, 2, 32'h4_0002};
	int bn [6] = '{2, 2, 4, 4, 2, 8};
	int be [6] = '{64, 32, 12, 12, 12, 20};
	usdbm_regs #(.TO_W(8)) u_usdbm_regs (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .mode, .rx_valid,
		.rx_char, .rx_sync_kind, .tx_take, .tx_done, .iso_err, .rx_halves_valid, .rx_halves, .tx_pre_start,
		.tx_out, .line_cfg, .rx_char_avail, .baud_tick, .bit_tick, .rx_idle_expired, .tx_guard_busy,
		.tx_pre_busy, .tx_pre_halves, .rx_pre_found);
	usdbm_line_partner u_usdbm_line_partner (.clk, .rx_valid, .rx_char, .rx_sync_kind, .tx_take, .tx_done,
		.iso_err, .rx_halves_valid, .rx_halves, .tx_pre_start);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ****
	// Tasks
	// ****
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic near(input string what, input int c, input int e);
		chk(what, 32'd1, {31'd0, c >= e - 1 && c <= e + 2});
	endtask
	task automatic count_ticks(input int cyc, output int c);
		c = 0;
		repeat (cyc) begin
			@(negedge clk);
			if ((bit_tick | baud_tick) !== 1'b0) c++;
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(what, exp, rdata);
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return bit_tick;
			1: return rx_idle_expired;
			2: return tx_guard_busy;
			default: return tx_pre_busy;
		endcase
	endfunction
	task automatic wait_lvl(input int k, input logic lvl, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (sig(k) !== lvl && c < 3000);
		if (c >= 3000) begin
			chk("wait bound", 32'd0, 32'd1);
			tally_and_finish();
		end
	endtask
	task automatic ticks(input int nt, output int tot);
		int c;
		tot = 0;
		wait_lvl(0, 1'b1, c);
		wait_lvl(0, 1'b0, c);
		wait_lvl(0, 1'b1, c);
		repeat (nt) begin
			wait_lvl(0, 1'b0, c);
			tot += c;
			wait_lvl(0, 1'b1, c);
			tot += c;
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		mode = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			rchk("reset value", ra[i], rr[i]);
			wreg(ra[i], 32'hFFFF_FFFF);
			rchk("write mask", ra[i], rm[i]);
		end
		$display("test registers done");
		wreg(usdbm_pkg::OFF_CARD_RATIO, 32'h0000_0003);
		wreg(usdbm_pkg::OFF_BAUD_DIV, 32'h0000_0000);
		@(posedge clk);
		mode <= 5'h10;
		count_ticks(200, n);
		chk("stopped ticks", 32'd0, n);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			mode <= bm[i];
			wreg(usdbm_pkg::OFF_BAUD_DIV, bd[i]);
			ticks(bn[i], n);
			chk("tick span", be[i], n);
		end
		@(posedge clk);
		mode <= 5'h04;
		wreg(usdbm_pkg::OFF_CARD_RATIO, 32'h0000_0000);
		count_ticks(200, n);
		chk("card ratio zero", 32'd0, n);
		@(posedge clk);
		mode <= 5'h10;
		$display("test baud done");
		wreg(usdbm_pkg::OFF_BAUD_DIV, 32'h0000_0002);
		wait_lvl(0, 1'b1, n);
		count_ticks(20, n);
		chk("baud ticks", 32'd10, n);
		wreg(usdbm_pkg::OFF_RX_IDLE, 32'h0000_0105);
		u_usdbm_line_partner.pulse(0, 9'h1A5, 1'b1);
		@(negedge clk);
		chk("char available", 32'd1, {31'd0, rx_char_avail});
		rchk("rx hold", usdbm_pkg::OFF_RX_HOLD, 32'h0000_81A5);
		chk("char cleared", 32'd0, {31'd0, rx_char_avail});
		u_usdbm_line_partner.pulse(0, 9'h05A, 1'b0);
		wait_lvl(1, 1'b1, n);
		near("idle span", n, 10);
		rchk("rx hold data", usdbm_pkg::OFF_RX_HOLD, 32'h0000_005A);
		wreg(usdbm_pkg::OFF_RX_IDLE, 32'h0000_0000);
		repeat (2) @(negedge clk);
		chk("idle off", 32'd0, {31'd0, rx_idle_expired});
		wreg(usdbm_pkg::OFF_TX_GUARD, 32'h0000_0004);
		u_usdbm_line_partner.pulse(2, 9'h000, 1'b0);
		wait_lvl(2, 1'b0, n);
		near("guard span", n, 8);
		wreg(usdbm_pkg::OFF_BIPHASE, 32'h0000_1203);
		wait_lvl(0, 1'b1, n);
		u_usdbm_line_partner.pulse(5, 9'h000, 1'b0);
		@(negedge clk);
		chk("preamble first", 32'h0000_0002, {30'd0, tx_pre_halves});
		@(negedge clk);
		chk("preamble second", 32'h0000_0001, {30'd0, tx_pre_halves});
		wait_lvl(3, 1'b0, m);
		near("preamble span", m + 2, 6);
		chk("preamble idle", 32'h0000_0000, {30'd0, tx_pre_halves});
		wreg(usdbm_pkg::OFF_BIPHASE, 32'h1102_0000);
		u_usdbm_line_partner.pulse(4, 9'h002, 1'b0);
		@(negedge clk);
		chk("preamble partial", 32'd0, {31'd0, rx_pre_found});
		u_usdbm_line_partner.pulse(4, 9'h002, 1'b0);
		@(negedge clk);
		chk("preamble found", 32'd1, {31'd0, rx_pre_found});
		@(negedge clk);
		chk("found pulse", 32'd0, {31'd0, rx_pre_found});
		$display("test timing done");
		@(posedge clk);
		mode <= 5'h11;
		wreg(usdbm_pkg::OFF_TX_HOLD, 32'h0000_8123);
		@(negedge clk);
		chk("tx pending", 32'h0000_048E, tx_out);
		u_usdbm_line_partner.pulse(1, 9'h000, 1'b0);
		@(negedge clk);
		chk("hold free", 32'd1, {31'd0, tx_out.hold_free});
		wreg(usdbm_pkg::OFF_TX_HOLD, 32'h0000_0045);
		@(negedge clk);
		chk("tx data", 32'h0000_0114, tx_out);
		repeat (3) u_usdbm_line_partner.pulse(3, 9'h000, 1'b0);
		rchk("error count", usdbm_pkg::OFF_ISO_ERR, 32'h0000_0003);
		rchk("error cleared", usdbm_pkg::OFF_ISO_ERR, 32'h0000_0000);
		$display("test transfer done");
		tally_and_finish();
	end
endmodule
